// ==== include/spq_pkg.sv ====
// Purpose: shared constants for the serial configuration and fifo port
// Assumes: 8-bit register words, 5-bit register addresses
// Notes: host command registers sit on an apb slave inside the host end
package spq_pkg;
  // device register map, page 0
  localparam logic [4:0] REG_MAIN_CHIP_MODE = 5'H00;
  localparam logic [4:0] REG_DATA_MODE = 5'H01;
  localparam logic [4:0] REG_INTERRUPT_CONFIG_FIRST = 5'H0C;
  localparam logic [4:0] REG_RECEIVE_CONFIG_FIRST = 5'H10;
  localparam logic [4:0] REG_SYNC_PATTERN_CONFIG_FIRST = 5'H16;
  localparam logic [4:0] REG_TRANSMIT_CONFIG = 5'H1A;
  localparam logic [4:0] REG_OSCILLATOR_CLOCK_OUT_CONFIG = 5'H1B;
  localparam logic [4:0] REG_PACKET_LENGTH_CONFIG = 5'H1C;
  localparam logic [4:0] REG_PAGE_AND_FIFO_CONFIG = 5'H1F;
  localparam int REG_COUNT = 32;
  localparam int PAGE1_COUNT = 2;
  // reset values
  localparam logic [7:0] CFG_RST = 8'H00;
  localparam logic [7:0] DATA_MODE_RST = 8'H24;
  // field positions
  localparam int CHIP_MODE_LSB = 5;
  localparam int DATA_MODE_LSB = 6;
  localparam int FIFO_READ_DIRECTION_BIT = 6;
  localparam int PAGE_SELECT_BIT = 0;
  localparam int CMD_RW_BIT = 6;
  localparam int CMD_ADDR_LSB = 1;
  // field codes
  localparam logic [2:0] CHIP_MODE_RECEIVE = 3'H3;
  localparam logic [1:0] DATA_MODE_CONTINUOUS = 2'H0;
  localparam int FIFO_DEPTH_DEF = 64;
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCK_PERIOD_NS = 400;
  localparam int SCK_HALF_CYC = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  // host apb registers
  localparam logic [7:0] HOST_CMD_OFF = 8'H00;
  localparam logic [7:0] HOST_STATUS_OFF = 8'H04;
  localparam int HCMD_FIFO_BIT = 8;
  localparam int HCMD_HOLD_BIT = 9;
  localparam int HSTAT_BUSY_BIT = 0;
  localparam int HSTAT_HOST_INTERRUPT_ZERO_BIT = 16;
  localparam int HSTAT_HOST_INTERRUPT_ONE_BIT = 17;
  localparam int HSTAT_RX_LSB = 8;
endpackage : spq_pkg

// ==== include/spq_if.sv ====
// Purpose: serial link between host master and device slave
// Assumes: host drives clock and both selects
// Notes: all signals are single-driver, no two-way pins
`timescale 1ns/1ps
interface spq_if;
  logic sck;
  logic serial_in;
  logic serial_out;
  logic config_select_n;
  logic fifo_select_n;
  logic host_interrupt_zero;
  logic host_interrupt_one;
  modport dev (
    input sck,
    input serial_in,
    input config_select_n,
    input fifo_select_n,
    output serial_out,
    output host_interrupt_zero,
    output host_interrupt_one
  );
  modport host (
    output sck,
    output serial_in,
    output config_select_n,
    output fifo_select_n,
    input serial_out,
    input host_interrupt_zero,
    input host_interrupt_one
  );
endinterface : spq_if

// ==== core/spq_shift.sv ====
// Purpose: 8-bit full-duplex byte shifter with bit counter
// Assumes: rise and fall are one-cycle edge pulses on pclk
// Notes: no shift at a byte boundary so a freshly loaded byte keeps its msb
`timescale 1ns/1ps
module spq_shift (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic rise,
  input wire logic fall,
  input wire logic sample,
  input wire logic load,
  input wire logic [7:0] load_data,
  output logic tx_bit,
  output logic [7:0] rx_byte,
  output logic done
);
  import spq_pkg::*;
  logic [2:0] cnt_q;
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic done_q;
  wire at_boundary = (cnt_q == 3'H0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 3'H0;
      rx_q <= 8'H00;
      done_q <= 1'b0;
    end else if (clear) begin
      cnt_q <= 3'H0;
      done_q <= 1'b0;
    end else if (rise) begin
      rx_q <= {rx_q[6:0], sample};
      cnt_q <= cnt_q + 3'H1;
      done_q <= (cnt_q == 3'H7);
    end else begin
      done_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_q <= 8'H00;
    end else if (load) begin
      tx_q <= load_data;
    end else if (fall && !at_boundary) begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  assign tx_bit = tx_q[7];
  assign rx_byte = rx_q;
  assign done = done_q;
endmodule : spq_shift

// ==== core/spq_dev.sv ====
// Purpose: device end of the serial configuration and fifo port
// Assumes: link pins come from the host domain and are resynchronised
// Notes: fifo direction follows chip mode or the read-direction bit
//
// Chosen here: no APB slave port; registers are reached over the serial link.
`timescale 1ns/1ps
module spq_dev #(
  parameter int FIFO_DEPTH = spq_pkg::FIFO_DEPTH_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  spq_if.dev link,
  input wire logic radio_wr_valid,
  input wire logic [7:0] radio_wr_data,
  output logic radio_wr_ready,
  input wire logic radio_rd_ready,
  output logic radio_rd_valid,
  output logic [7:0] radio_rd_data,
  output logic [2:0] chip_mode,
  output logic [1:0] data_mode
);
  import spq_pkg::*;
  localparam int AW = $clog2(FIFO_DEPTH);
  localparam logic [AW:0] DEPTH_W = (AW + 1)'(FIFO_DEPTH);
  localparam logic [AW-1:0] LAST_W = AW'(FIFO_DEPTH - 1);

  // two-flop synchronisers: {config_select_n, fifo_select_n, sck, serial_in}
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic sck_prev_q;
  logic cfg_prev_q;
  logic fifo_prev_q;
  logic cfg_act;
  logic fifo_act;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 4'HC;
      sync_q <= 4'HC;
      sck_prev_q <= 1'b0;
      cfg_prev_q <= 1'b0;
      fifo_prev_q <= 1'b0;
    end else begin
      meta_q <= {link.config_select_n, link.fifo_select_n, link.sck, link.serial_in};
      sync_q <= meta_q;
      sck_prev_q <= sync_q[1];
      cfg_prev_q <= cfg_act;
      fifo_prev_q <= fifo_act;
    end
  end

  wire cfg_n_s = sync_q[3];
  wire fifo_n_s = sync_q[2];
  wire sck_s = sync_q[1];
  wire sin_s = sync_q[0];
  wire sck_rise = sck_s & ~sck_prev_q;
  wire sck_fall = ~sck_s & sck_prev_q;

  // configuration storage
  logic [7:0] regs_q [REG_COUNT];
  logic [7:0] page1_q [PAGE1_COUNT];
  logic expect_addr_q;
  logic [4:0] addr_q;

  assign chip_mode = regs_q[REG_MAIN_CHIP_MODE][CHIP_MODE_LSB +: 3];
  assign data_mode = regs_q[REG_DATA_MODE][DATA_MODE_LSB +: 2];
  wire page1 = regs_q[REG_PAGE_AND_FIFO_CONFIG][PAGE_SELECT_BIT];
  wire rd_dir = regs_q[REG_PAGE_AND_FIFO_CONFIG][FIFO_READ_DIRECTION_BIT]
                | (chip_mode == CHIP_MODE_RECEIVE);
  wire fifo_mode = (data_mode != DATA_MODE_CONTINUOUS);

  assign cfg_act = ~cfg_n_s;
  // fifo port needs buffered or packet mode
  assign fifo_act = cfg_n_s & ~fifo_n_s & fifo_mode;
  wire sel_act = cfg_act | fifo_act;
  wire cfg_start = cfg_act & ~cfg_prev_q;
  wire cfg_end = ~cfg_act & cfg_prev_q;
  wire fifo_start = fifo_act & ~fifo_prev_q;

  logic byte_done;
  logic [7:0] rx_byte;
  logic tx_bit;
  wire cfg_done = byte_done & cfg_act;
  wire fifo_done = byte_done & fifo_act;

  // command decode
  wire cmd_read = rx_byte[CMD_RW_BIT];
  wire [4:0] cmd_addr = rx_byte[CMD_ADDR_LSB +: 5];
  wire [7:0] page0_rd = regs_q[cmd_addr];
  wire [7:0] page1_rd = (cmd_addr < 5'(PAGE1_COUNT)) ? page1_q[cmd_addr[0]] : 8'H00;
  wire [7:0] cfg_rd = page1 ? page1_rd : page0_rd;
  wire cfg_is_cmd = cfg_done & expect_addr_q;
  wire cfg_is_data = cfg_done & ~expect_addr_q;
  wire cfg_read = cfg_is_cmd & cmd_read;

  // fifo storage
  logic [7:0] fifo_q [FIFO_DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  wire fifo_empty = (count_q == '0);
  wire fifo_full = (count_q == DEPTH_W);
  wire [7:0] fifo_head = fifo_q[rd_ptr_q];

  wire host_wr = fifo_done & ~rd_dir & ~fifo_full;
  wire host_rd = fifo_done & rd_dir & ~fifo_empty;
  wire radio_wr = radio_wr_valid & rd_dir & ~fifo_full;
  wire radio_rd = radio_rd_ready & ~rd_dir & ~fifo_empty;
  wire fifo_wr = host_wr | radio_wr;
  wire fifo_rd = host_rd | radio_rd;
  wire [7:0] fifo_wdata = host_wr ? rx_byte : radio_wr_data;

  // reply byte for the next transfer
  // config read data rides the following byte; the fifo head rides the fifo byte it is loaded for
  wire load_w = cfg_start | fifo_start | cfg_done;
  wire [7:0] load_byte = fifo_start ? (rd_dir ? fifo_head : 8'H00)
                         : (cfg_read ? cfg_rd : 8'H00);

  spq_shift u_shift (
    .pclk(pclk),
    .presetn(presetn),
    .clear(~sel_act),
    .rise(sck_rise),
    .fall(sck_fall),
    .sample(sin_s),
    .load(load_w),
    .load_data(load_byte),
    .tx_bit(tx_bit),
    .rx_byte(rx_byte),
    .done(byte_done)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      expect_addr_q <= 1'b1;
      addr_q <= 5'H00;
    end else if (cfg_end) begin
      expect_addr_q <= 1'b1;
    // command byte holds rw and address
    end else if (cfg_is_cmd) begin
      addr_q <= cmd_addr;
      expect_addr_q <= cmd_read;
    end else if (cfg_is_data) begin
      expect_addr_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_q[i] <= CFG_RST;
      end
      regs_q[REG_DATA_MODE] <= DATA_MODE_RST;
      page1_q[0] <= CFG_RST;
      page1_q[1] <= CFG_RST;
    end else if (cfg_is_data) begin
      if (!page1) begin
        regs_q[addr_q] <= rx_byte;
      end else if (addr_q < 5'(PAGE1_COUNT)) begin
        page1_q[addr_q[0]] <= rx_byte;
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (fifo_wr) begin
      fifo_q[wr_ptr_q] <= fifo_wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (fifo_wr) begin
        wr_ptr_q <= (wr_ptr_q == LAST_W) ? '0 : wr_ptr_q + 1'b1;
      end
      if (fifo_rd) begin
        rd_ptr_q <= (rd_ptr_q == LAST_W) ? '0 : rd_ptr_q + 1'b1;
      end
      if (fifo_wr && !fifo_rd) begin
        count_q <= count_q + 1'b1;
      end else if (fifo_rd && !fifo_wr) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  logic host_interrupt_zero_q;
  logic host_interrupt_one_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_interrupt_zero_q <= 1'b0;
      host_interrupt_one_q <= 1'b0;
    end else begin
      host_interrupt_zero_q <= ~fifo_empty;
      host_interrupt_one_q <= fifo_full;
    end
  end

  assign link.serial_out = tx_bit;
  assign link.host_interrupt_zero = host_interrupt_zero_q;
  assign link.host_interrupt_one = host_interrupt_one_q;
  assign radio_wr_ready = rd_dir & ~fifo_full;
  assign radio_rd_valid = ~rd_dir & ~fifo_empty;
  assign radio_rd_data = fifo_head;
endmodule : spq_dev

// ==== core/spq_host.sv ====
// Purpose: host master end, driven by software over apb
// Assumes: one command register write starts one byte
// Notes: serial clock is pclk divided; reply bit read late in the high phase
`timescale 1ns/1ps
module spq_host #(
  parameter int HALF = spq_pkg::SCK_HALF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  spq_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import spq_pkg::*;
  typedef enum {ST_IDLE, ST_LEAD, ST_HIGH, ST_LOW, ST_GAP} spq_hstate_t;
  localparam logic [7:0] HALF_M1 = 8'(HALF - 1);
  localparam logic [7:0] GAP_M1 = 8'(2 * HALF - 1);

  spq_hstate_t state_q;
  logic [7:0] tick_q;
  logic [3:0] bits_q;
  logic sck_q;
  logic cfg_n_q;
  logic fifo_n_q;
  logic hold_q;
  logic [7:0] rx_q;
  logic [31:0] prdata_q;
  logic [2:0] meta_q;
  logic [2:0] sync_q;

  wire busy = (state_q != ST_IDLE);
  wire tick_end = (tick_q == HALF_M1);
  wire setup = psel & ~penable;
  wire cmd_wr = psel & penable & pwrite & (paddr[7:0] == HOST_CMD_OFF) & ~busy;
  wire rise_p = (state_q == ST_HIGH) & tick_end;
  wire fall_p = (state_q == ST_LOW) & (tick_q == 8'H00);
  wire [31:0] status = {14'H0000, sync_q[1], sync_q[2], rx_q, 7'H00, busy};

  logic done;
  logic [7:0] rx_byte;
  logic tx_bit;

  spq_shift u_shift (
    .pclk(pclk),
    .presetn(presetn),
    .clear(~busy),
    .rise(rise_p),
    .fall(fall_p),
    .sample(sync_q[0]),
    .load(cmd_wr),
    .load_data(pwdata[7:0]),
    .tx_bit(tx_bit),
    .rx_byte(rx_byte),
    .done(done)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 3'H0;
      sync_q <= 3'H0;
      prdata_q <= 32'H00000000;
      rx_q <= 8'H00;
    end else begin
      meta_q <= {link.host_interrupt_one, link.host_interrupt_zero, link.serial_out};
      sync_q <= meta_q;
      if (setup) begin
        prdata_q <= (paddr[7:0] == HOST_STATUS_OFF) ? status : 32'H00000000;
      end
      if (done) begin
        rx_q <= rx_byte;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      tick_q <= 8'H00;
      bits_q <= 4'H0;
      sck_q <= 1'b0;
      cfg_n_q <= 1'b1;
      fifo_n_q <= 1'b1;
      hold_q <= 1'b0;
    end else begin
      tick_q <= tick_q + 8'H01;
      case (state_q)
        ST_IDLE: begin
          tick_q <= 8'H00;
          if (cmd_wr) begin
            cfg_n_q <= pwdata[HCMD_FIFO_BIT];
            fifo_n_q <= ~pwdata[HCMD_FIFO_BIT];
            hold_q <= pwdata[HCMD_HOLD_BIT];
            bits_q <= 4'H0;
            state_q <= ST_LEAD;
          end
        end
        ST_LEAD: begin
          if (tick_end) begin
            sck_q <= 1'b1;
            tick_q <= 8'H00;
            state_q <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (tick_end) begin
            sck_q <= 1'b0;
            bits_q <= bits_q + 4'H1;
            tick_q <= 8'H00;
            state_q <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (tick_end) begin
            tick_q <= 8'H00;
            if (bits_q != 4'H8) begin
              sck_q <= 1'b1;
              state_q <= ST_HIGH;
            end else if (hold_q) begin
              state_q <= ST_IDLE;
            end else begin
              cfg_n_q <= 1'b1;
              fifo_n_q <= 1'b1;
              state_q <= ST_GAP;
            end
          end
        end
        ST_GAP: begin
          if (tick_q == GAP_M1) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign link.sck = sck_q;
  assign link.serial_in = tx_bit;
  assign link.config_select_n = cfg_n_q;
  assign link.fifo_select_n = fifo_n_q;
  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
endmodule : spq_host

// ==== bench/spq_properties.sv ====
// Purpose: link checks between host end and device end
// Assumes: host half period of four clocks
// Notes: watches interface wires only, no design internals
`timescale 1ns/1ps
module spq_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sck,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic config_select_n,
  input wire logic fifo_select_n,
  input wire logic host_interrupt_zero,
  input wire logic host_interrupt_one
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [4:0] rises_q;
  logic [4:0] rises_d;
  logic sck_q;
  wire logic both_idle = config_select_n && fifo_select_n;
  // counts link clock rises in one select period; wraps, byte check uses the low three bits, fifo check all five
  assign rises_d = both_idle ? 5'H00 : rises_q + {4'H0, sck && !sck_q};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rises_q <= 5'H00;
      sck_q <= 1'b0;
    end else begin
      rises_q <= rises_d;
      sck_q <= sck;
    end
  end
  a_sck_selected: assert property (sck |-> !both_idle)
    else $error("link clock active with no select low");
  a_sdi_steady: assert property (sck && $past(sck) |-> $stable(serial_in))
    else $error("host data changed while link clock high");
  a_sck_high_width: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
    else $error("link clock high phase not four clocks");
  a_sck_low_width: assert property ($fell(sck) |-> !sck [*4])
    else $error("link clock low phase too short");
  a_select_lead: assert property ($fell(config_select_n) || $fell(fifo_select_n) |-> !sck [*4])
    else $error("link clock rose too soon after select");
  a_byte_whole: assert property ($rose(config_select_n) || $rose(fifo_select_n)
    |-> rises_q[2:0] == 3'H0)
    else $error("select released inside a byte");
  a_fifo_one_byte: assert property ($rose(fifo_select_n) |-> rises_q == 5'H08)
    else $error("fifo select period not exactly one byte");
  a_irq_order: assert property (host_interrupt_one |-> host_interrupt_zero)
    else $error("full flag without not-empty flag");
  cover property ($fell(config_select_n));
  cover property ($fell(fifo_select_n));
  cover property ($rose(host_interrupt_one));
endmodule : spq_properties

// ==== bench/tb_spi_config_and_fifo_port.sv ====
// Purpose: drives the host end over apb and the device radio side
// Assumes: fifo depth 8 so the full state is reachable quickly
// Notes: radio drain side is tied off; fifo is emptied over the link
`timescale 1ns/1ps
module tb_spi_config_and_fifo_port;
  import spq_pkg::*;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic radio_wr_valid;
  logic [7:0] radio_wr_data;
  logic radio_wr_ready;
  logic [1:0] data_mode;
  int failures;
  int compares;
  int n;
  logic [31:0] rx;
  logic [31:0] word;
  spq_if u_spq_if ();
  spq_host u_spq_host (.pclk(pclk), .presetn(presetn), .link(u_spq_if.host), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr());
  spq_dev #(.FIFO_DEPTH(8)) u_spq_dev (.pclk(pclk), .presetn(presetn), .link(u_spq_if.dev),
    .radio_wr_valid(radio_wr_valid), .radio_wr_data(radio_wr_data),
    .radio_wr_ready(radio_wr_ready), .radio_rd_ready(1'b0), .radio_rd_valid(),
    .radio_rd_data(), .chip_mode(), .data_mode(data_mode));
  spq_properties u_spq_properties (.pclk(pclk), .presetn(presetn), .sck(u_spq_if.sck),
    .serial_in(u_spq_if.serial_in), .serial_out(u_spq_if.serial_out),
    .config_select_n(u_spq_if.config_select_n), .fifo_select_n(u_spq_if.fifo_select_n),
    .host_interrupt_zero(u_spq_if.host_interrupt_zero),
    .host_interrupt_one(u_spq_if.host_interrupt_one));
  task automatic close_out();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // one apb transfer; an idle edge follows so back-to-back calls never collide
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {24'H0, a};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // one link byte, then wait for busy to clear and fetch the reply
  task automatic xfer(input logic [7:0] b, input logic fifo, input logic hold,
                      output logic [31:0] r);
    logic [31:0] st;
    int k;
    apb(1'b1, HOST_CMD_OFF, {22'H0, hold, fifo, b}, st);
    k = 0;
    do begin
      apb(1'b0, HOST_STATUS_OFF, 32'H0, st);
      k++;
    end while (st[HSTAT_BUSY_BIT] !== 1'b0 && k < 500);
    if (k >= 500) failures++;
    r = {24'H0, st[HSTAT_RX_LSB +: 8]};
  endtask : xfer
  function automatic logic [7:0] cmd(input logic rd, input logic [4:0] a);
    return {1'b0, rd, a, 1'b0};
  endfunction : cmd
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    repeat (60000) @(posedge pclk);
    failures++;
    close_out();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'H0;
    pwdata = 32'H0;
    radio_wr_valid = 1'b0;
    radio_wr_data = 8'H30;
    failures = 0;
    compares = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(cmd(1'b1, REG_DATA_MODE), 1'b0, 1'b1, rx);
    xfer(cmd(1'b1, REG_PAGE_AND_FIFO_CONFIG), 1'b0, 1'b1, rx);
    check(rx, 32'H24);
    xfer(8'H00, 1'b0, 1'b0, rx);
    check(rx, 32'H00);
    check({30'H0, data_mode}, 32'H0);
    apb(1'b0, 8'H08, 32'H0, word);
    check(word, 32'H0);
    $display("test reset values done");
    xfer(cmd(1'b0, REG_TRANSMIT_CONFIG), 1'b0, 1'b1, rx);
    xfer(8'HA5, 1'b0, 1'b1, rx);
    xfer(cmd(1'b0, REG_OSCILLATOR_CLOCK_OUT_CONFIG), 1'b0, 1'b1, rx);
    xfer(8'H5A, 1'b0, 1'b0, rx);
    xfer(cmd(1'b0, REG_PACKET_LENGTH_CONFIG), 1'b0, 1'b0, rx);
    xfer(cmd(1'b0, REG_SYNC_PATTERN_CONFIG_FIRST), 1'b0, 1'b1, rx);
    xfer(8'H3C, 1'b0, 1'b0, rx);
    xfer(cmd(1'b1, REG_TRANSMIT_CONFIG), 1'b0, 1'b1, rx);
    xfer(cmd(1'b1, REG_OSCILLATOR_CLOCK_OUT_CONFIG), 1'b0, 1'b1, rx);
    check(rx, 32'HA5);
    xfer(cmd(1'b1, REG_PACKET_LENGTH_CONFIG), 1'b0, 1'b1, rx);
    check(rx, 32'H5A);
    xfer(cmd(1'b1, REG_SYNC_PATTERN_CONFIG_FIRST), 1'b0, 1'b1, rx);
    check(rx, 32'H00);
    xfer(8'H00, 1'b0, 1'b0, rx);
    check(rx, 32'H3C);
    $display("test config access done");
    xfer(cmd(1'b0, REG_DATA_MODE), 1'b0, 1'b1, rx);
    xfer(8'H64, 1'b0, 1'b1, rx);
    xfer(cmd(1'b0, REG_PAGE_AND_FIFO_CONFIG), 1'b0, 1'b1, rx);
    xfer(8'H40, 1'b0, 1'b0, rx);
    check({30'H0, data_mode}, 32'H1);
    n = 0;
    radio_wr_valid <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      @(negedge pclk);
      if (radio_wr_ready === 1'b1) begin
        n++;
        @(posedge pclk);
        radio_wr_data <= radio_wr_data + 8'H01;
      end
    end
    @(posedge pclk);
    radio_wr_valid <= 1'b0;
    check(n, 32'H8);
    repeat (4) @(posedge pclk);
    apb(1'b0, HOST_STATUS_OFF, 32'H0, word);
    check({30'H0, word[HSTAT_HOST_INTERRUPT_ONE_BIT:HSTAT_HOST_INTERRUPT_ZERO_BIT]}, 32'H3);
    // continuous mode: this fifo byte must leave the pointer alone
    xfer(cmd(1'b0, REG_DATA_MODE), 1'b0, 1'b1, rx);
    xfer(8'H24, 1'b0, 1'b0, rx);
    xfer(8'H00, 1'b1, 1'b0, rx);
    xfer(cmd(1'b0, REG_DATA_MODE), 1'b0, 1'b1, rx);
    xfer(8'H64, 1'b0, 1'b0, rx);
    for (int i = 0; i < 8; i++) begin
      xfer(8'H00, 1'b1, 1'b0, rx);
      check(rx, 32'H30 + i);
    end
    apb(1'b0, HOST_STATUS_OFF, 32'H0, word);
    check({30'H0, word[HSTAT_HOST_INTERRUPT_ONE_BIT:HSTAT_HOST_INTERRUPT_ZERO_BIT]}, 32'H0);
    $display("test fifo access done");
    close_out();
  end
endmodule : tb_spi_config_and_fifo_port
